/* File: status_pkg.sv */
package status_pkg;

    // Status byte bit positions
    localparam int STB_MEAS_BIT = 0;
    localparam int STB_UNUSED_BIT = 1;
    localparam int STB_ERR_BIT = 2;
    localparam int STB_QUEST_BIT = 3;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_STD_BIT = 5;
    localparam int STB_MSS_BIT = 6;
    localparam int STB_OPER_BIT = 7;

    // Writable enable bits: 7,5,4,3,2,0 (6 and 1 are held at zero)
    localparam logic [7:0] SRE_WMASK = 8'hBD;
    localparam logic [7:0] SRE_RST_VAL = 8'h00;
    localparam logic [7:0] STB_RST_VAL = 8'h00;
    localparam logic [7:0] OPC_ASCII_ONE = 8'h31;

    // Setup word layout: {trigger source, configuration}
    localparam int CFG_W = 16;
    localparam int TSRC_W = 2;
    localparam int SETUP_W = CFG_W + TSRC_W;

    // Trigger control source codes
    localparam logic [TSRC_W-1:0] TSRC_IMM = 2'h0;
    localparam logic [TSRC_W-1:0] TSRC_BUS = 2'h1;
    localparam logic [TSRC_W-1:0] TSRC_TIMER = 2'h2;
    localparam logic [TSRC_W-1:0] TSRC_EXT = 2'h3;

    // Reset defaults and factory preset of the controls
    localparam logic [TSRC_W-1:0] TSRC_RST_VAL = TSRC_IMM;
    localparam logic [CFG_W-1:0] CFG_RST_VAL = 16'h0000;
    localparam logic [TSRC_W-1:0] TSRC_PRESET = TSRC_IMM;
    localparam logic [CFG_W-1:0] CFG_PRESET = 16'h0000;
    localparam logic [SETUP_W-1:0] SETUP_PRESET = {TSRC_PRESET, CFG_PRESET};

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_SRE_WR = 4'h1,
        CMD_SRE_RD = 4'h2,
        CMD_STB_RD = 4'h3,
        CMD_RST = 4'h4,
        CMD_SAV = 4'h5,
        CMD_RCL = 4'h6,
        CMD_TRG = 4'h7,
        CMD_OPC = 4'h8,
        CMD_OPC_RD = 4'h9,
        CMD_CFG_WR = 4'hA,
        CMD_TSRC_WR = 4'hB
    } cmd_e;

endpackage : status_pkg

/* File: setup_if.sv */
`timescale 1ns/1ps
interface setup_if #(
    parameter int W = 18
);
    logic wr;
    logic rd;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic rvalid;
    logic rerr;

    modport ctrl (output wr, output rd, output wdata, input rdata, input rvalid, input rerr);
    modport store (input wr, input rd, input wdata, output rdata, output rvalid, output rerr);
endinterface : setup_if

/* File: setup_store.sv */
`timescale 1ns/1ps
module setup_store import status_pkg::*; #(
    parameter int W = SETUP_W,
    parameter logic [W-1:0] PRESET = SETUP_PRESET
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Backing store reports a bad read
    input wire logic fault_i,
    // Access port
    setup_if.store bus
);
    // One slot, kept with a parity bit so a corrupted slot is caught on recall
    logic [W:0] slot_r, slot_nxt;
    logic [W-1:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic rerr_r, rerr_nxt;
    logic bad;

    always_comb begin
        slot_nxt = slot_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        rerr_nxt = 1'b0;
        bad = fault_i || (^slot_r);
        if (bus.wr) begin
            slot_nxt = {^bus.wdata, bus.wdata};
        end else if (bus.rd) begin
            rvalid_nxt = 1'b1;
            rerr_nxt = bad;
            rdata_nxt = bad ? PRESET : slot_r[W-1:0];
            if (bad) begin
                slot_nxt = {^PRESET, PRESET};
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_r <= {^PRESET, PRESET};
            rdata_r <= PRESET;
            rvalid_r <= 1'b0;
            rerr_r <= 1'b0;
        end else if (ce_i) begin
            slot_r <= slot_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            rerr_r <= rerr_nxt;
        end
    end

    assign bus.rdata = rdata_r;
    assign bus.rvalid = rvalid_r;
    assign bus.rerr = rerr_r;
endmodule : setup_store

/* File: trig_gate.sv */
`timescale 1ns/1ps
module trig_gate import status_pkg::*; (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Trigger sources
    input wire logic trg_cmd_i,
    input wire logic get_i,
    input wire logic [TSRC_W-1:0] src_i,
    // Trigger event
    output logic trig_o
);
    logic trig_nxt;

    always_comb begin
        trig_nxt = (trg_cmd_i || get_i) && (src_i == TSRC_BUS);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_o <= 1'b0;
        end else if (ce_i) begin
            trig_o <= trig_nxt;
        end
    end
endmodule : trig_gate

/* File: status_byte_service_request.sv */
`timescale 1ns/1ps
module status_byte_service_request import status_pkg::*; #(
    parameter int CW = CFG_W
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Command port
    input wire logic cmd_valid_i,
    input cmd_e cmd_code_i,
    input wire logic [CW-1:0] cmd_data_i,
    output logic cmd_ready_o,
    // Summary inputs from lower registers and queues
    input wire logic meas_event_i,
    input wire logic err_queue_i,
    input wire logic quest_cal_i,
    input wire logic std_event_i,
    input wire logic oper_event_i,
    // Overlapped operations still running
    input wire logic op_busy_i,
    // Bus messages
    input wire logic talk_i,
    input wire logic spoll_i,
    input wire logic get_i,
    // Setup store fault
    input wire logic store_fault_i,
    // Responses
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic spoll_valid_o,
    output logic [7:0] spoll_data_o,
    // Status
    output logic [7:0] stb_o,
    output logic srq_o,
    output logic opc_event_o,
    output logic trig_o,
    // Controls
    output logic [TSRC_W-1:0] trig_src_o,
    output logic [CW-1:0] cfg_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RCL_WAIT = 2'b10
    } state_e;

    setup_if #(.W(TSRC_W + CW)) sbus ();

    state_e state_r, state_nxt;
    logic [7:0] sre_r, sre_nxt;
    logic [7:0] stb_r, stb_nxt;
    logic srq_r, srq_nxt;
    logic oq_full_r, oq_full_nxt;
    logic [7:0] oq_data_r, oq_data_nxt;
    logic resp_valid_r, resp_valid_nxt;
    logic [7:0] resp_data_r, resp_data_nxt;
    logic spoll_valid_r, spoll_valid_nxt;
    logic [7:0] spoll_data_r, spoll_data_nxt;
    logic opcq_pend_r, opcq_pend_nxt;
    logic opc_pend_r, opc_pend_nxt;
    logic opc_evt_r, opc_evt_nxt;
    logic [TSRC_W-1:0] tsrc_r, tsrc_nxt;
    logic [CW-1:0] cfg_r, cfg_nxt;
    logic ready_r, ready_nxt;
    logic trg_cmd_r, trg_cmd_nxt;
    logic acc;
    logic [7:0] stb_low;
    logic mss;
    logic enq;
    logic [7:0] enq_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte and summary

    always_comb begin
        stb_low = 8'h00;
        stb_low[STB_MEAS_BIT] = meas_event_i;
        stb_low[STB_UNUSED_BIT] = 1'b0;
        stb_low[STB_ERR_BIT] = err_queue_i;
        stb_low[STB_QUEST_BIT] = quest_cal_i;
        stb_low[STB_MAV_BIT] = oq_full_r;
        stb_low[STB_STD_BIT] = std_event_i;
        stb_low[STB_OPER_BIT] = oper_event_i;
        mss = |(stb_low & sre_r);
        stb_nxt = stb_low;
        stb_nxt[STB_MSS_BIT] = mss;
        srq_nxt = mss;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode, output queue and setup control

    assign acc = cmd_valid_i && ready_r;

    always_comb begin
        state_nxt = state_r;
        sre_nxt = sre_r;
        opcq_pend_nxt = opcq_pend_r;
        opc_pend_nxt = opc_pend_r;
        opc_evt_nxt = 1'b0;
        tsrc_nxt = tsrc_r;
        cfg_nxt = cfg_r;
        trg_cmd_nxt = 1'b0;
        enq = 1'b0;
        enq_data = 8'h00;
        sbus.wr = 1'b0;
        sbus.rd = 1'b0;
        sbus.wdata = {tsrc_r, cfg_r};
        case (state_r)
            ST_IDLE: begin
                if (acc) begin
                    case (cmd_code_i)
                        CMD_SRE_WR: begin
                            sre_nxt = cmd_data_i[7:0] & SRE_WMASK;
                        end
                        CMD_SRE_RD: begin
                            enq = 1'b1;
                            enq_data = sre_r;
                        end
                        CMD_STB_RD: begin
                            // Reading leaves the status byte alone
                            enq = 1'b1;
                            enq_data = stb_r;
                        end
                        CMD_RST: begin
                            tsrc_nxt = TSRC_RST_VAL;
                            cfg_nxt = CFG_RST_VAL;
                            opcq_pend_nxt = 1'b0;
                            opc_pend_nxt = 1'b0;
                        end
                        CMD_SAV: begin
                            sbus.wr = 1'b1;
                        end
                        CMD_RCL: begin
                            sbus.rd = 1'b1;
                            state_nxt = ST_RCL_WAIT;
                        end
                        CMD_TRG: begin
                            trg_cmd_nxt = 1'b1;
                        end
                        CMD_OPC: begin
                            opc_pend_nxt = 1'b1;
                        end
                        CMD_OPC_RD: begin
                            opcq_pend_nxt = 1'b1;
                        end
                        CMD_CFG_WR: begin
                            cfg_nxt = cmd_data_i;
                        end
                        CMD_TSRC_WR: begin
                            tsrc_nxt = cmd_data_i[TSRC_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
                // Completion is only signalled once no overlapped work is left
                if (!op_busy_i && !acc) begin
                    if (opcq_pend_r) begin
                        enq = 1'b1;
                        enq_data = OPC_ASCII_ONE;
                        opcq_pend_nxt = 1'b0;
                    end
                    if (opc_pend_r) begin
                        opc_evt_nxt = 1'b1;
                        opc_pend_nxt = 1'b0;
                    end
                end
            end
            ST_RCL_WAIT: begin
                if (sbus.rvalid) begin
                    // Store already substitutes the preset on a failed read
                    {tsrc_nxt, cfg_nxt} = sbus.rdata;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        ready_nxt = (state_nxt == ST_IDLE);
    end

    // Output queue holds one message; a newer message replaces an unread one
    always_comb begin
        oq_full_nxt = oq_full_r;
        oq_data_nxt = oq_data_r;
        resp_valid_nxt = 1'b0;
        resp_data_nxt = resp_data_r;
        spoll_valid_nxt = 1'b0;
        spoll_data_nxt = spoll_data_r;
        if (talk_i && oq_full_r) begin
            resp_valid_nxt = 1'b1;
            resp_data_nxt = oq_data_r;
            oq_full_nxt = 1'b0;
        end
        // Enqueue after the read so a new message is never lost
        if (enq) begin
            oq_full_nxt = 1'b1;
            oq_data_nxt = enq_data;
        end
        if (spoll_i) begin
            spoll_valid_nxt = 1'b1;
            spoll_data_nxt = stb_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            sre_r <= SRE_RST_VAL;
            stb_r <= STB_RST_VAL;
            srq_r <= 1'b0;
            oq_full_r <= 1'b0;
            oq_data_r <= 8'h00;
            resp_valid_r <= 1'b0;
            resp_data_r <= 8'h00;
            spoll_valid_r <= 1'b0;
            spoll_data_r <= 8'h00;
            opcq_pend_r <= 1'b0;
            opc_pend_r <= 1'b0;
            opc_evt_r <= 1'b0;
            tsrc_r <= TSRC_RST_VAL;
            cfg_r <= CFG_RST_VAL;
            ready_r <= 1'b0;
            trg_cmd_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            sre_r <= sre_nxt;
            stb_r <= stb_nxt;
            srq_r <= srq_nxt;
            oq_full_r <= oq_full_nxt;
            oq_data_r <= oq_data_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r <= resp_data_nxt;
            spoll_valid_r <= spoll_valid_nxt;
            spoll_data_r <= spoll_data_nxt;
            opcq_pend_r <= opcq_pend_nxt;
            opc_pend_r <= opc_pend_nxt;
            opc_evt_r <= opc_evt_nxt;
            tsrc_r <= tsrc_nxt;
            cfg_r <= cfg_nxt;
            ready_r <= ready_nxt;
            trg_cmd_r <= trg_cmd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules

    setup_store #(
        .W(TSRC_W + CW),
        .PRESET({TSRC_PRESET, CFG_PRESET[CW-1:0]})
    ) u_store (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .fault_i(store_fault_i),
        .bus(sbus.store)
    );

    trig_gate u_trig (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .trg_cmd_i(trg_cmd_r),
        .get_i(get_i),
        .src_i(tsrc_r),
        .trig_o(trig_o)
    );

    assign cmd_ready_o = ready_r;
    assign resp_valid_o = resp_valid_r;
    assign resp_data_o = resp_data_r;
    assign spoll_valid_o = spoll_valid_r;
    assign spoll_data_o = spoll_data_r;
    assign stb_o = stb_r;
    assign srq_o = srq_r;
    assign opc_event_o = opc_evt_r;
    assign trig_src_o = tsrc_r;
    assign cfg_o = cfg_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sre_write_mask_a: assert property (
        (ce_i && acc && cmd_code_i == CMD_SRE_WR)
        |=> (sre_r == ($past(cmd_data_i[7:0]) & SRE_WMASK)) && !sre_r[6] && !sre_r[1])
        else $error("enable register write not masked correctly");

    sre_query_a: assert property (
        (ce_i && acc && cmd_code_i == CMD_SRE_RD)
        |=> oq_full_r && (oq_data_r == $past(sre_r)))
        else $error("enable query returned wrong value");

    summary_srq_a: assert property (
        ce_i |=> (srq_o == stb_o[6]) && (stb_o[6] == |($past(stb_low) & $past(sre_r))))
        else $error("summary bit does not follow enabled status bits");

    stb_unused_a: assert property (
        ce_i |=> !stb_o[1] && (stb_o[4] == $past(oq_full_r)))
        else $error("status byte bit 1 or 4 wrong");

    reset_cmd_a: assert property (
        (ce_i && acc && cmd_code_i == CMD_RST)
        |=> !opcq_pend_r && !opc_pend_r && trig_src_o == TSRC_RST_VAL
            && cfg_o == CFG_RST_VAL[CW-1:0])
        else $error("reset command left state behind");

    opc_query_a: assert property (
        (ce_i && opcq_pend_r && !op_busy_i && !acc && state_r == ST_IDLE)
        |=> oq_full_r && oq_data_r == OPC_ASCII_ONE && stb_low[4])
        else $error("completion query did not queue ascii one");

    bus_trigger_a: assert property (
        (ce_i && acc && cmd_code_i == CMD_TRG && !get_i) ##1 ce_i
        |=> (trig_o == ($past(tsrc_r) == TSRC_BUS)))
        else $error("trigger command not gated by source");

    recall_done_a: assert property (
        (ce_i && acc && cmd_code_i == CMD_RCL) ##1 ce_i
        |=> state_r == ST_IDLE && cmd_ready_o
            && (!$past(sbus.rerr)
                || ({trig_src_o, cfg_o} == {TSRC_PRESET, CFG_PRESET[CW-1:0]})))
        else $error("recall did not complete in time");

endmodule : status_byte_service_request

/* File: host_model.sv */
`timescale 1ns/1ps
module host_model import status_pkg::*; (
    // Clock
    input wire logic sys_clk_i,
    // Command port
    input wire logic cmd_ready_i,
    output logic cmd_valid_o,
    output cmd_e cmd_code_o,
    output logic [CFG_W-1:0] cmd_data_o,
    // Bus messages
    output logic talk_o,
    output logic spoll_o,
    output logic get_o,
    // Responses
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_data_i,
    input wire logic spoll_valid_i,
    input wire logic [7:0] spoll_data_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = CMD_NONE;
        cmd_data_o = 16'h5A5A;
        talk_o = 1'b0;
        spoll_o = 1'b0;
        get_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request held until an edge samples ready high; left up so commands can abut
    task automatic send(input cmd_e code, input logic [CFG_W-1:0] data);
        int n;
        n = 0;
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_data_o <= data;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (cmd_ready_i !== 1'b1 && n < 50);
    endtask : send

    // Released data lines toggle so a stale value is never mistaken for data
    task automatic idle(input int n);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= CMD_NONE;
        cmd_data_o <= ~cmd_data_o;
        repeat (n) @(posedge sys_clk_i);
    endtask : idle

    // Enable mask sent as a decimal sum of bit weights
    task automatic sre_write(input int dec);
        send(CMD_SRE_WR, CFG_W'(dec));
    endtask : sre_write

    task automatic talk(output logic [7:0] d);
        d = 8'hxx;
        talk_o <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge sys_clk_i);
            if (resp_valid_i === 1'b1) begin
                d = resp_data_i;
                break;
            end
        end
        talk_o <= 1'b0;
    endtask : talk

    // Request bit read by serial poll as an alternative to the query
    task automatic poll(output logic [7:0] d);
        d = 8'hxx;
        spoll_o <= 1'b1;
        @(posedge sys_clk_i);
        spoll_o <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge sys_clk_i);
            if (spoll_valid_i === 1'b1) begin
                d = spoll_data_i;
                break;
            end
        end
    endtask : poll

    task automatic group_trigger();
        get_o <= 1'b1;
        @(posedge sys_clk_i);
        get_o <= 1'b0;
    endtask : group_trigger
endmodule : host_model

/* File: status_byte_service_request_bench.sv */
`timescale 1ns/1ps
module status_byte_service_request_bench import status_pkg::*;;
    logic sys_clk, rst, ce, cmd_valid, cmd_ready, op_busy, talk, spoll, get, fault;
    cmd_e cmd_code;
    logic [CFG_W-1:0] cmd_data, cfg;
    logic [7:0] ev, resp_data, spoll_data, stb, d;
    logic resp_valid, spoll_valid, srq, opc_event, trig;
    logic [TSRC_W-1:0] trig_src;
    int bad_count, n_checks, cycles, trig_n, opc_n, exp_trig;
    logic [7:0] sre_in [10] = '{8'hFF, 8'h80, 8'h30, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20,
                                8'h42, 8'h00};
    int ev_pos [5] = '{0, 2, 3, 5, 7};

    status_byte_service_request DUT (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
        .cmd_ready_o(cmd_ready), .meas_event_i(ev[0]), .err_queue_i(ev[2]),
        .quest_cal_i(ev[3]), .std_event_i(ev[5]), .oper_event_i(ev[7]),
        .op_busy_i(op_busy), .talk_i(talk), .spoll_i(spoll), .get_i(get),
        .store_fault_i(fault), .resp_valid_o(resp_valid), .resp_data_o(resp_data),
        .spoll_valid_o(spoll_valid), .spoll_data_o(spoll_data), .stb_o(stb), .srq_o(srq),
        .opc_event_o(opc_event), .trig_o(trig), .trig_src_o(trig_src), .cfg_o(cfg));

    host_model host (.sys_clk_i(sys_clk), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
        .cmd_code_o(cmd_code), .cmd_data_o(cmd_data), .talk_o(talk), .spoll_o(spoll),
        .get_o(get), .resp_valid_i(resp_valid), .resp_data_i(resp_data),
        .spoll_valid_i(spoll_valid), .spoll_data_i(spoll_data));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic query(input cmd_e code, output logic [7:0] q);
        host.send(code, 16'h0000);
        host.idle(0);
        host.talk(q);
    endtask : query

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (trig === 1'b1) trig_n++;
        if (opc_event === 1'b1) opc_n++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ev = 8'h00;
        op_busy = 1'b0;
        fault = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("stb after reset", stb, 8'h00);
        query(CMD_SRE_RD, d);
        check("enable after reset", d, 8'h00);
        // Enable writes, including the two bits that must not stick
        foreach (sre_in[i]) begin
            host.sre_write(sre_in[i]);
            host.idle(1);
            query(CMD_SRE_RD, d);
            check("enable readback", d, sre_in[i] & 8'hBD);
        end
        // Each summary input alone, masked then enabled
        foreach (ev_pos[i]) begin
            ev <= 8'h01 << ev_pos[i];
            repeat (3) @(posedge sys_clk);
            check("stb masked", {srq, stb}, {1'b0, 8'h01 << ev_pos[i]});
            host.sre_write(1 << ev_pos[i]);
            host.idle(3);
            check("stb enabled", {srq, stb}, {1'b1, 8'h40 | (8'h01 << ev_pos[i])});
            ev <= 8'h00;
            repeat (3) @(posedge sys_clk);
            check("stb cleared", {srq, stb}, 9'h000);
            host.sre_write(0);
            host.idle(1);
        end
        // Poll and query both see the request and neither clears it
        host.sre_write(32);
        host.idle(0);
        ev <= 8'h20;
        repeat (3) @(posedge sys_clk);
        host.poll(d);
        check("poll byte", d, 8'h60);
        query(CMD_STB_RD, d);
        check("stb query", d, 8'h60);
        host.idle(2);
        check("stb kept", stb, 8'h60);
        ev <= 8'h00;
        host.sre_write(16);
        host.send(CMD_SRE_RD, 16'h0000);
        host.idle(3);
        check("message waiting", stb, 8'h50);
        host.talk(d);
        check("message text", d, 8'h10);
        host.idle(2);
        check("message gone", stb, 8'h00);
        // Trigger command and bus trigger under every source code
        for (int s = 0; s < 4; s++) begin
            host.send(CMD_TSRC_WR, CFG_W'(s));
            host.send(CMD_TRG, 16'h0000);
            host.idle(4);
            host.group_trigger();
            host.idle(4);
            exp_trig += (TSRC_W'(s) == TSRC_BUS) ? 2 : 0;
            check("trigger count", trig_n, exp_trig);
        end
        // Save, reset command, recall and overwrite of the single slot
        host.send(CMD_CFG_WR, 16'hA5C3);
        host.send(CMD_TSRC_WR, {14'h0000, TSRC_BUS});
        host.send(CMD_SAV, 16'h0000);
        host.send(CMD_RST, 16'h0000);
        host.idle(2);
        check("reset controls", {trig_src, cfg}, {TSRC_IMM, 16'h0000});
        host.send(CMD_RCL, 16'h0000);
        host.idle(4);
        check("recall controls", {trig_src, cfg}, {TSRC_BUS, 16'hA5C3});
        host.send(CMD_CFG_WR, 16'h1234);
        host.send(CMD_SAV, 16'h0000);
        host.send(CMD_CFG_WR, 16'h0F0F);
        host.send(CMD_RCL, 16'h0000);
        host.idle(4);
        check("slot overwrite", cfg, 16'h1234);
        fault <= 1'b1;
        host.send(CMD_RCL, 16'h0000);
        host.idle(4);
        check("failed recall", {trig_src, cfg}, {TSRC_IMM, 16'h0000});
        fault <= 1'b0;
        host.send(CMD_CFG_WR, 16'h7777);
        host.send(CMD_RCL, 16'h0000);
        host.idle(4);
        check("slot preset", cfg, 16'h0000);
        // Completion owed while busy is dropped by the reset command
        op_busy <= 1'b1;
        host.send(CMD_OPC_RD, 16'h0000);
        host.send(CMD_OPC, 16'h0000);
        host.send(CMD_RST, 16'h0000);
        host.idle(3);
        op_busy <= 1'b0;
        host.idle(5);
        check("owed completion", {opc_n[7:0], stb}, 16'h0000);
        host.send(CMD_OPC_RD, 16'h0000);
        host.idle(4);
        check("completion waiting", stb[4], 1'b1);
        host.talk(d);
        check("completion text", d, 8'h31);
        host.send(CMD_OPC, 16'h0000);
        host.idle(4);
        check("completion event", opc_n, 1);
        // Enable low freezes everything: command and status change are both held off
        ce <= 1'b0;
        ev <= 8'h01;
        host.send(CMD_CFG_WR, 16'h5555);
        host.idle(3);
        check("frozen state", {stb, cfg}, 24'h00_0000);
        ce <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("after freeze", stb, 8'h01);
        ev <= 8'h00;
        // Mid-run reset clears the enable register again
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        query(CMD_SRE_RD, d);
        check("enable after second reset", d, 8'h00);
        end_of_test();
    end
endmodule : status_byte_service_request_bench
